// ### inc/adc_alarm_pkg.sv
// Purpose: Shared constants for the converter frame and alarm control block
// Assumes: 8 analog channels plus one auxiliary channel, 16-bit command words
// Notes:   Command opcodes and hysteresis width are local choices
package adc_alarm_pkg;
   localparam int          DATA_W      = 14;
   localparam int          NUM_CH      = 8;
   localparam int          CH_W        = 4;
   localparam int          HYST_W      = 8;
   localparam int          CMD_W       = 16;
   localparam int          CNT_W       = 5;
   localparam int          CALC_W      = 17;
   localparam int          FIFO_DEPTH  = 4;
   localparam int          FIFO_W      = CH_W + DATA_W;
   localparam int          FLAG_W      = 2 * NUM_CH;
   // Auxiliary input bypasses the front end, unipolar only, no alarm
   localparam logic [CH_W-1:0]   AUX_CH      = 4'h8;
   localparam logic [CH_W-1:0]   CH_RESET    = 4'h0;
   // Falling-edge counts before the named edge
   localparam logic [CNT_W-1:0]  EDGE16_CNT  = 5'h0F;
   localparam logic [CNT_W-1:0]  CNT_MAX     = 5'h1F;
   localparam logic [CNT_W-1:0]  CNT_RESET   = 5'h00;
   // Alarm limit offsets
   localparam logic [CALC_W-1:0] HI_CLR_OFS  = 17'h00002;
   localparam logic [CALC_W-1:0] LO_SET_OFS  = 17'h00001;
   localparam logic [CALC_W-1:0] LO_CLR_OFS  = 17'h00001;
   // Command word: opcode in the top nibble, channel in the next
   localparam int          OP_HI       = 15;
   localparam int          OP_LO       = 12;
   localparam int          CMD_CH_HI   = 11;
   localparam int          CMD_CH_LO   = 8;
   localparam logic [3:0]  OP_MANUAL   = 4'hC;
   localparam logic [3:0]  OP_AUTO     = 4'hA;
   localparam logic [CMD_W-1:0]  CMD_RESET   = 16'h0000;
   localparam logic [DATA_W-1:0] CODE_ZERO   = 14'h0000;
   localparam logic [FLAG_W-1:0] FLAG_RESET  = 16'h0000;
   typedef enum logic {SCAN_MANUAL, SCAN_AUTO} scan_mode_t;
endpackage

// ### hdl/result_fifo.sv
// Purpose: Small synchronous FIFO between converter and serial output
// Assumes: Single clock, flip-flop storage
// Notes:   Full drops in_ready; the frame logic then skips conversions
`timescale 1ns/10ps
module result_fifo
#(
   parameter int WIDTH = 18,
   parameter int DEPTH = 4
)
(
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST = (AW)'(DEPTH - 1);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_r;
   logic [AW-1:0]    rd_r;
   logic [AW:0]      cnt_r;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_r != DEPTH_C);
   assign out_valid = (cnt_r != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_r[rd_r];

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem_r[wr_r] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_r <= (wr_r == LAST) ? '0 : wr_r + 1'b1;
         end
         if (pop)
         begin
            rd_r <= (rd_r == LAST) ? '0 : rd_r + 1'b1;
         end
         if (push && !pop)
         begin
            cnt_r <= cnt_r + 1'b1;
         end
         else if (pop && !push)
         begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end

   a_fifo_no_overflow : assert property (@(posedge clk) disable iff (!arst_n)
      cnt_r <= DEPTH_C)
      else $error("fifo count above depth");
endmodule

// ### hdl/adc_alarm_and_frame_control.sv
// Purpose: Frame control, serial output and per-channel alarms of a 14-bit SAR converter
// Assumes: Serial pins asynchronous to clk; converter core on clk reports done
// Notes:   Serial clock must be slow enough for clk to see every edge
//
// How it works
// - Alarm loads OR of tripped flags at each sixteenth fall
// - Alarm changes only on sixteenth falling edge
// - Each analog channel has high, low alarm settings
// - High alarm sets above threshold plus hysteresis
// - High alarm clears at threshold minus hysteresis minus two
// - Low alarm sets below threshold minus hysteresis minus one
// - Low alarm clears at threshold plus hysteresis plus one
// - Active flag follows the alarm condition
// - Tripped flag latches until flag read
// - Results are straight binary on all channels
// - Results are fourteen bits wide
// - Step size scales with selected range
// - Auxiliary channel unipolar, no front end gain
// - Chip select fall samples and starts conversion
// - Converted channel chosen in previous frame
// - Configuration accepted while conversion runs
// - Idle while chip select high
// - Input captured first sixteen edges, applied next frame
// - Output low fifteen edges, then MSB first
// - Auto scan steps enabled channels ascending
`timescale 1ns/10ps
module adc_alarm_and_frame_control
   import adc_alarm_pkg::*;
(
   input  wire logic                       clk,
   input  wire logic                       arst_n,
   input  wire logic                       cs_n,
   input  wire logic                       sclk,
   input  wire logic                       sdi,
   output logic                            sdo,
   output logic                            sdo_oe,
   output logic                            alarm,
   input  wire logic [NUM_CH-1:0]          scan_enable,
   input  wire logic [NUM_CH*DATA_W-1:0]   high_thresh,
   input  wire logic [NUM_CH*HYST_W-1:0]   high_hyst,
   input  wire logic [NUM_CH*DATA_W-1:0]   low_thresh,
   input  wire logic [NUM_CH*HYST_W-1:0]   low_hyst,
   input  wire logic                       flags_read,
   output logic [FLAG_W-1:0]               active_flags,
   output logic [FLAG_W-1:0]               tripped_flags,
   output logic                            conv_start,
   output logic [CH_W-1:0]                 conv_channel,
   input  wire logic                       conv_done,
   input  wire logic [DATA_W-1:0]          conv_code
);
   logic              cs_s1_r, cs_s2_r, cs_d_r;
   logic              sclk_s1_r, sclk_s2_r, sclk_d_r;
   logic              sdi_s1_r, sdi_s2_r;
   logic              cs_fall;
   logic              in_frame;
   logic              sclk_fall;
   logic              edge16;
   logic [CNT_W-1:0]  fall_cnt_r;
   logic [CMD_W-1:0]  cmd_sr_r;
   logic [CMD_W-1:0]  cmd_word;
   logic [CMD_W-1:0]  pend_cmd_r;
   logic              pend_valid_r;
   scan_mode_t        mode_r;
   scan_mode_t        mode_nxt;
   logic [CH_W-1:0]   man_ch_r;
   logic [CH_W-1:0]   man_ch_nxt;
   logic [CH_W-1:0]   sel_ch_r;
   logic [CH_W-1:0]   ch_now;
   logic [DATA_W-1:0] out_sr_r;
   logic              fifo_in_ready;
   logic              fifo_out_valid;
   logic [FIFO_W-1:0] fifo_out_data;
   logic [DATA_W-1:0] load_code;
   logic [NUM_CH-1:0] hi_now, lo_now;

   // Two-flop synchronisers for the serial pins
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cs_s1_r   <= 1'b1;
         cs_s2_r   <= 1'b1;
         cs_d_r    <= 1'b1;
         // Idle-high reset values, so no false edge follows reset
         sclk_s1_r <= 1'b1;
         sclk_s2_r <= 1'b1;
         sclk_d_r  <= 1'b1;
         sdi_s1_r  <= 1'b0;
         sdi_s2_r  <= 1'b0;
      end
      else
      begin
         cs_s1_r   <= cs_n;
         cs_s2_r   <= cs_s1_r;
         cs_d_r    <= cs_s2_r;
         sclk_s1_r <= sclk;
         sclk_s2_r <= sclk_s1_r;
         sclk_d_r  <= sclk_s2_r;
         sdi_s1_r  <= sdi;
         sdi_s2_r  <= sdi_s1_r;
      end
   end

   assign cs_fall   = cs_d_r && !cs_s2_r;
   assign in_frame  = !cs_s2_r;
   // Edges while chip select is high are ignored
   assign sclk_fall = in_frame && sclk_d_r && !sclk_s2_r;
   assign edge16    = sclk_fall && (fall_cnt_r == EDGE16_CNT);
   assign cmd_word  = {cmd_sr_r[CMD_W-2:0], sdi_s2_r};

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fall_cnt_r <= CNT_RESET;
      end
      else if (!in_frame)
      begin
         fall_cnt_r <= CNT_RESET;
      end
      else if (sclk_fall && fall_cnt_r != CNT_MAX)
      begin
         fall_cnt_r <= fall_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cmd_sr_r     <= CMD_RESET;
         pend_cmd_r   <= CMD_RESET;
         pend_valid_r <= 1'b0;
      end
      else
      begin
         if (sclk_fall && fall_cnt_r <= EDGE16_CNT)
         begin
            cmd_sr_r <= cmd_word;
         end
         if (edge16)
         begin
            pend_cmd_r   <= cmd_word;
            pend_valid_r <= 1'b1;
         end
         else if (cs_fall)
         begin
            pend_valid_r <= 1'b0;
         end
      end
   end

   // pending command applied at frame start
   always_comb
   begin
      mode_nxt   = mode_r;
      man_ch_nxt = man_ch_r;
      if (pend_valid_r && pend_cmd_r[OP_HI:OP_LO] == OP_MANUAL)
      begin
         mode_nxt   = SCAN_MANUAL;
         man_ch_nxt = pend_cmd_r[CMD_CH_HI:CMD_CH_LO];
      end
      else if (pend_valid_r && pend_cmd_r[OP_HI:OP_LO] == OP_AUTO)
      begin
         mode_nxt = SCAN_AUTO;
      end
   end

   // Manual pick from the last frame is converted at this very sample
   assign ch_now = (mode_nxt == SCAN_AUTO) ? sel_ch_r : man_ch_nxt;

   // next enabled channel, ascending with wrap
   function automatic logic [CH_W-1:0] next_scan(input logic [CH_W-1:0] cur,
                                                 input logic [NUM_CH-1:0] en);
      logic [CH_W-1:0] res;
      logic            found;
      int              idx;
      res   = cur;
      found = 1'b0;
      for (int k = 1; k <= NUM_CH; k++)
      begin
         idx = (int'(cur) + k) % NUM_CH;
         if (!found && en[idx])
         begin
            res   = CH_W'(idx);
            found = 1'b1;
         end
      end
      return res;
   endfunction

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mode_r       <= SCAN_MANUAL;
         man_ch_r     <= CH_RESET;
         sel_ch_r     <= CH_RESET;
         conv_start   <= 1'b0;
         conv_channel <= CH_RESET;
      end
      else
      begin
         // no conversion outside a chip-select fall
         conv_start <= 1'b0;
         if (cs_fall)
         begin
            // sample and start on chip-select fall
            // Full FIFO skips the conversion rather than losing a result
            conv_start   <= fifo_in_ready;
            // channel picked in the previous frame
            conv_channel <= ch_now;
            mode_r       <= mode_nxt;
            man_ch_r     <= man_ch_nxt;
            if (mode_nxt == SCAN_AUTO)
            begin
               sel_ch_r <= next_scan(sel_ch_r, scan_enable);
            end
            else
            begin
               sel_ch_r <= man_ch_nxt;
            end
         end
      end
   end

   // same straight-binary word for every channel
   result_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .clk       (clk),
      .arst_n    (arst_n),
      .in_valid  (conv_done),
      .in_ready  (fifo_in_ready),
      .in_data   ({conv_channel, conv_code}),
      .out_valid (fifo_out_valid),
      .out_ready (edge16),
      .out_data  (fifo_out_data)
   );

   assign load_code = fifo_out_valid ? fifo_out_data[DATA_W-1:0] : CODE_ZERO;

   // low until edge sixteen, then MSB first, zeros after
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sdo      <= 1'b0;
         sdo_oe   <= 1'b0;
         out_sr_r <= CODE_ZERO;
      end
      else
      begin
         sdo_oe <= in_frame;
         if (!in_frame)
         begin
            sdo      <= 1'b0;
            out_sr_r <= CODE_ZERO;
         end
         else if (edge16)
         begin
            sdo      <= load_code[DATA_W-1];
            out_sr_r <= {load_code[DATA_W-2:0], 1'b0};
         end
         else if (sclk_fall && fall_cnt_r > EDGE16_CNT)
         begin
            sdo      <= out_sr_r[DATA_W-1];
            out_sr_r <= {out_sr_r[DATA_W-2:0], 1'b0};
         end
      end
   end

   // one high and one low alarm per analog channel
   generate
      for (genvar c = 0; c < NUM_CH; c++)
      begin : g_ch
         logic [CALC_W-1:0] code_x, ht, hh, lt, lh;
         logic              upd;
         assign code_x = CALC_W'(conv_code);
         assign ht     = CALC_W'(high_thresh[c*DATA_W +: DATA_W]);
         assign hh     = CALC_W'(high_hyst[c*HYST_W +: HYST_W]);
         assign lt     = CALC_W'(low_thresh[c*DATA_W +: DATA_W]);
         assign lh     = CALC_W'(low_hyst[c*HYST_W +: HYST_W]);
         // once per finished conversion of this channel
         assign upd    = conv_done && (conv_channel == CH_W'(c));
         always_comb
         begin
            hi_now[c] = active_flags[2*c+1];
            lo_now[c] = active_flags[2*c];
            if ($signed(code_x) > $signed(ht + hh))
            begin
               hi_now[c] = 1'b1;
            end
            // clear at or below lower limit
            else if ($signed(code_x) <= $signed(ht - hh - HI_CLR_OFS))
            begin
               hi_now[c] = 1'b0;
            end
            if ($signed(code_x) < $signed(lt - lh - LO_SET_OFS))
            begin
               lo_now[c] = 1'b1;
            end
            // clear at or above upper limit
            else if ($signed(code_x) >= $signed(lt + lh + LO_CLR_OFS))
            begin
               lo_now[c] = 1'b0;
            end
         end
         always_ff @(posedge clk or negedge arst_n)
         begin
            if (!arst_n)
            begin
               active_flags[2*c+1 -: 2]  <= 2'h0;
               tripped_flags[2*c+1 -: 2] <= 2'h0;
            end
            else
            begin
               if (upd)
               begin
                  active_flags[2*c+1] <= hi_now[c];
                  active_flags[2*c]   <= lo_now[c];
               end
               // latched until read; a new set beats the read
               tripped_flags[2*c+1] <= (tripped_flags[2*c+1] && !flags_read)
                                       || (upd && hi_now[c]);
               tripped_flags[2*c]   <= (tripped_flags[2*c] && !flags_read)
                                       || (upd && lo_now[c]);
            end
         end
      end
   endgenerate

   // any tripped flag raises the pin
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         alarm <= 1'b0;
      end
      else if (edge16)
      begin
         alarm <= |tripped_flags;
      end
   end

   a_alarm_on_edge16 : assert property (@(posedge clk) disable iff (!arst_n)
      $changed(alarm) |-> $past(edge16))
      else $error("alarm changed away from edge sixteen");

   a_alarm_follows_trip : assert property (@(posedge clk) disable iff (!arst_n)
      edge16 |=> (alarm == $past(|tripped_flags)))
      else $error("alarm does not reflect tripped flags");

   a_sdo_low_early : assert property (@(posedge clk) disable iff (!arst_n)
      (in_frame && fall_cnt_r <= EDGE16_CNT && !$past(edge16)) |-> !sdo)
      else $error("sdo not low before edge sixteen");

   a_start_on_csfall : assert property (@(posedge clk) disable iff (!arst_n)
      conv_start |-> $past(cs_fall))
      else $error("conversion started without chip-select fall");

   a_idle_cs_high : assert property (@(posedge clk) disable iff (!arst_n)
      (cs_s2_r && cs_d_r) |=> !conv_start)
      else $error("conversion while chip select high");

   a_prev_frame_ch : assert property (@(posedge clk) disable iff (!arst_n)
      cs_fall |=> (conv_channel == $past(ch_now)))
      else $error("converted channel not the previous selection");

   a_hi_alarm_set : assert property (@(posedge clk) disable iff (!arst_n)
      (conv_done && conv_channel < CH_W'(NUM_CH)
       && CALC_W'(conv_code) > CALC_W'(high_thresh[conv_channel*DATA_W +: DATA_W])
          + CALC_W'(high_hyst[conv_channel*HYST_W +: HYST_W]))
      |=> active_flags[2*conv_channel+1] && tripped_flags[2*conv_channel+1])
      else $error("high alarm not set above limit");

   a_hi_alarm_clear : assert property (@(posedge clk) disable iff (!arst_n)
      (conv_done && conv_channel < CH_W'(NUM_CH) && $signed(CALC_W'(conv_code)) <=
       $signed(CALC_W'(high_thresh[conv_channel*DATA_W +: DATA_W])
          - CALC_W'(high_hyst[conv_channel*HYST_W +: HYST_W]) - HI_CLR_OFS))
      |=> !active_flags[2*conv_channel+1])
      else $error("high alarm not cleared at lower limit");

   a_trip_held : assert property (@(posedge clk) disable iff (!arst_n)
      !$past(flags_read) |-> ((tripped_flags & $past(tripped_flags)) == $past(tripped_flags)))
      else $error("tripped flag lost without read");

   a_active_hold : assert property (@(posedge clk) disable iff (!arst_n)
      !$past(conv_done) |-> $stable(active_flags))
      else $error("active flags moved without a conversion");

   c_frame_read : cover property (@(posedge clk) disable iff (!arst_n)
      edge16 && fifo_out_valid);
   c_alarm_raise : cover property (@(posedge clk) disable iff (!arst_n)
      $rose(alarm));
   c_auto_scan : cover property (@(posedge clk) disable iff (!arst_n)
      cs_fall && mode_nxt == SCAN_AUTO);
   c_set_and_read : cover property (@(posedge clk) disable iff (!arst_n)
      flags_read && conv_done);
endmodule

// ### sim/spi_host_model.sv
// Purpose: Host model that runs one serial frame for each start request
// Assumes: Link clock of 125 ns, idle high, still between frames
// Notes:   Result bits are read one fall after the device presents them
`timescale 1ns/10ps
module spi_host_model
(
   input  wire logic        start,
   input  wire logic [15:0] cmd,
   input  wire logic        sdo,
   output logic             cs_n,
   output logic             sclk,
   output logic             sdi,
   output logic             busy,
   output logic             lead_low,
   output logic [13:0]      rx_word
);
   int i;

   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b1;
      sdi = 1'b0;
      busy = 1'b0;
      lead_low = 1'b0;
      rx_word = 14'h0000;
   end

   always @(posedge start)
   begin
      busy = 1'b1;
      lead_low = 1'b1;
      #37 cs_n = 1'b0;
      #100;
      for (i = 1; i <= 30; i++)
      begin
         // command MSB first; later bits are junk that must be ignored
         sdi = (i <= 16) ? cmd[16-i] : ~sdi;
         #62.5 sclk = 1'b0;
         // Lead bits must be low; result bits follow
         if (i <= 16)
            lead_low = lead_low & (sdo === 1'b0);
         else
            rx_word = {rx_word[12:0], sdo};
         #62.5 sclk = 1'b1;
      end
      #100 cs_n = 1'b1;
      // Released data line shows the inverse, never a stale value
      sdi = ~sdi;
      #100 busy = 1'b0;
   end
endmodule

// ### sim/tb_adc_alarm_and_frame_control.sv
// Purpose: Self-checking bench for frame, result and alarm control
// Assumes: Converter core stand-in answers a set latency after each start
// Notes:   Alarm tests run in manual mode on channel 3
`timescale 1ns/10ps
module tb_adc_alarm_and_frame_control
   import adc_alarm_pkg::*;
;
   logic                     clk, arst_n, cs_n, sclk, sdi, sdo, sdo_oe, alarm;
   logic                     flags_read, conv_start, conv_done, start, busy, lead_low;
   logic [NUM_CH-1:0]        scan_enable;
   logic [NUM_CH*DATA_W-1:0] high_thresh, low_thresh;
   logic [NUM_CH*HYST_W-1:0] high_hyst, low_hyst;
   logic [FLAG_W-1:0]        active_flags, tripped_flags;
   logic [CH_W-1:0]          conv_channel, last_ch;
   logic [DATA_W-1:0]        conv_code, rx_word;
   logic [DATA_W-1:0]        code_tab [0:8];
   logic [15:0]              cmd;
   int                       miscompares, cmp_count, starts, dcnt, conv_lat;

   adc_alarm_and_frame_control adc_alarm_and_frame_control_inst
   (
      .clk, .arst_n, .cs_n, .sclk, .sdi, .sdo, .sdo_oe, .alarm, .scan_enable,
      .high_thresh, .high_hyst, .low_thresh, .low_hyst, .flags_read, .active_flags,
      .tripped_flags, .conv_start, .conv_channel, .conv_done, .conv_code
   );

   spi_host_model spi_host_model_inst
   (
      .start, .cmd, .sdo, .cs_n, .sclk, .sdi, .busy, .lead_low, .rx_word
   );

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Converter stand-in; latency is conv_lat, and the default of 6 keeps the result ahead of the 16th fall
   always @(posedge clk)
   begin
      conv_done <= 1'b0;
      if (conv_start === 1'b1)
      begin
         starts <= starts + 1;
         last_ch <= conv_channel;
         dcnt <= conv_lat;
      end
      else if (dcnt > 0)
      begin
         dcnt <= dcnt - 1;
         conv_done <= (dcnt == 1);
         conv_code <= code_tab[conv_channel];
      end
   end

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check_bit(input string name, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic frame(input logic [15:0] c);
      int n;
      n = 0;
      @(posedge clk);
      cmd <= c;
      start <= 1'b1;
      while (busy !== 1'b1 && n < 100)
      begin
         @(posedge clk);
         n++;
      end
      start <= 1'b0;
      while (busy !== 1'b0 && n < 1000)
      begin
         @(posedge clk);
         n++;
      end
      if (busy !== 1'b0)
      begin
         miscompares++;
      end
   endtask

   task automatic read_flags();
      @(posedge clk);
      flags_read <= 1'b1;
      @(posedge clk);
      flags_read <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task automatic alarm_step(input logic [13:0] code, input int b, input logic act,
                             input logic trip, input logic alm);
      code_tab[3] = code;
      frame(16'h0000);
      check_bit("active flag", act, active_flags[b]);
      check_bit("tripped flag", trip, tripped_flags[b]);
      check_bit("alarm pin", alm, alarm);
   endtask

   task automatic test_select();
      int s0;
      code_tab[0] = 14'h0123;
      code_tab[3] = 14'h2A5C;
      s0 = starts;
      frame(16'hC300);
      check_word("start count", 16'(s0 + 1), 16'(starts));
      check_word("frame channel", 16'h0000, {12'h000, last_ch});
      check_word("frame result", 16'h0123, {2'b00, rx_word});
      check_bit("lead bits low", 1'b1, lead_low);
      fork
         frame(16'h0000);
         begin
            repeat (40) @(posedge clk);
            check_bit("sdo enable", 1'b1, sdo_oe);
         end
      join
      check_bit("sdo released", 1'b0, sdo_oe);
      check_word("frame channel", 16'h0003, {12'h000, last_ch});
      check_word("frame result", 16'h2A5C, {2'b00, rx_word});
      s0 = starts;
      repeat (50) @(posedge clk);
      check_word("idle starts", 16'(s0), 16'(starts));
   endtask

   task automatic test_alarms();
      @(posedge clk);
      high_thresh[3*14+:14] <= 14'h03E8;
      high_hyst[3*8+:8] <= 8'h0A;
      alarm_step(14'h03F2, 7, 0, 0, 0);
      alarm_step(14'h03F3, 7, 1, 1, 1);
      alarm_step(14'h03DD, 7, 1, 1, 1);
      alarm_step(14'h03DC, 7, 0, 1, 1);
      read_flags();
      check_word("tripped after read", 16'h0000, tripped_flags);
      check_bit("alarm held to 16th fall", 1'b1, alarm);
      alarm_step(14'h03DC, 7, 0, 0, 0);
      low_thresh[3*14+:14] <= 14'h00C8;
      low_hyst[3*8+:8] <= 8'h05;
      alarm_step(14'h00C2, 6, 0, 0, 0);
      alarm_step(14'h00C1, 6, 1, 1, 1);
      alarm_step(14'h00CD, 6, 1, 1, 1);
      alarm_step(14'h00CE, 6, 0, 1, 1);
      check_bit("high flag apart", 1'b0, tripped_flags[7]);
      read_flags();
      alarm_step(14'h00CE, 6, 0, 0, 0);
   endtask

   task automatic test_scan();
      logic [3:0] exp_ch [0:3];
      exp_ch = '{4'h3, 4'h5, 4'h7, 4'h2};
      scan_enable <= 8'hA4;
      frame(16'hA000);
      for (int i = 0; i < 4; i++)
      begin
         frame(16'h0000);
         check_word("scan channel", {12'h000, exp_ch[i]}, {12'h000, last_ch});
      end
   endtask

   task automatic fifo_frame(input logic [13:0] code, input int lat, output logic [13:0] got);
      foreach (code_tab[j]) code_tab[j] = code;
      conv_lat = lat;
      frame(16'h0000);
      got = rx_word;
   endtask

   task automatic test_fifo();
      logic [13:0] got;
      // Slow conversions end after the 16th fall, so results lag one frame
      fifo_frame(14'h1111, 250, got);
      check_word("fifo empty result", 16'h0000, {2'b00, got});
      fifo_frame(14'h2222, 250, got);
      check_word("fifo result", 16'h1111, {2'b00, got});
      fifo_frame(14'h3333, 6, got);
      check_word("fifo result", 16'h2222, {2'b00, got});
      fifo_frame(14'h0444, 6, got);
      check_word("fifo result", 16'h3333, {2'b00, got});
   endtask

   initial
   begin
      #300000;
      miscompares++;
      finish_test();
   end

   initial
   begin
      arst_n = 1'b0;
      flags_read = 1'b0;
      start = 1'b0;
      cmd = 16'h0000;
      scan_enable = 8'h00;
      high_thresh = {NUM_CH{14'h3F00}};
      high_hyst = '0;
      low_thresh = '0;
      low_hyst = '0;
      conv_lat = 6;
      miscompares = 0;
      cmp_count = 0;
      starts = 0;
      dcnt = 0;
      conv_done = 1'b0;
      conv_code = 14'h0000;
      last_ch = 4'h0;
      foreach (code_tab[j]) code_tab[j] = 14'h0000;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      check_bit("alarm after reset", 1'b0, alarm);
      check_word("tripped after reset", 16'h0000, tripped_flags);
      test_select();
      test_alarms();
      test_scan();
      test_fifo();
      finish_test();
   end
endmodule
